/* iprm_regs.v */
// mid interrupt priority register bank behind an apb slave
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "iprm_defs.vh"

// Functional notes
// [R1] each field three bits, read-write, seven highest
// [R2] code one is lowest level, codes linear
// [R3] all-zero code disables the source
// [R4] unused bit positions always read zero
// [R5] reset loads every field with level four
// [R6] register zero: external interrupt one, bits 2-0
// [R7] register one: timer4, compare4, compare3 fields
// [R8] register two: serial tx, rx, ext2, timer5
// [R9] register three: spi event 6-4, fault 2-0
// [R10] register four: capture five, four, three
// [R11] register five: compare five at bits 6-4
// [R12] register six: parallel port at bits 6-4
// [R13] software may give all sources one nonzero level
// [R14] unused bits ignore writes; fields update next cycle
module iprm_regs #(
  parameter ADDR_W = `IPRM_ADDR_W
) (
  input  wire                    pclk,
  input  wire                    presetn,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [ADDR_W-1:0]       paddr,
  input  wire [`IPRM_DATA_W-1:0] pwdata,
  input  wire [3:0]              pstrb,
  output wire [`IPRM_DATA_W-1:0] prdata,
  output wire                    pready,
  output wire                    pslverr,
  output wire [2:0]              ext_irq1_level,
  output wire [2:0]              timer4_level,
  output wire [2:0]              compare4_level,
  output wire [2:0]              compare3_level,
  output wire [2:0]              serial2_tx_level,
  output wire [2:0]              serial2_rx_level,
  output wire [2:0]              ext_irq2_level,
  output wire [2:0]              timer5_level,
  output wire [2:0]              spi_unit2_event_level,
  output wire [2:0]              spi_unit2_fault_level,
  output wire [2:0]              capture5_level,
  output wire [2:0]              capture4_level,
  output wire [2:0]              capture3_level,
  output wire [2:0]              compare5_level,
  output wire [2:0]              parallel_port_level,
  output wire [14:0]             src_enabled
);

  localparam NF = `IPRM_NUM_FLDS;  // number of priority fields

  // register index of each field, field zero in the low bits
  localparam [3*NF-1:0] FLD_REG = {
    `IPRM_IDX_PARP,   // field 14, parallel port
    `IPRM_IDX_CMP5,   // field 13, compare five
    `IPRM_IDX_CAP,    // field 12, capture three
    `IPRM_IDX_CAP,    // field 11, capture four
    `IPRM_IDX_CAP,    // field 10, capture five
    `IPRM_IDX_SPI2,   // field 9, spi fault
    `IPRM_IDX_SPI2,   // field 8, spi event
    `IPRM_IDX_SER2,   // field 7, timer five
    `IPRM_IDX_SER2,   // field 6, external two
    `IPRM_IDX_SER2,   // field 5, serial receive
    `IPRM_IDX_SER2,   // field 4, serial transmit
    `IPRM_IDX_TMR4,   // field 3, compare three
    `IPRM_IDX_TMR4,   // field 2, compare four
    `IPRM_IDX_TMR4,   // field 1, timer four
    `IPRM_IDX_EXT1    // field 0, external one
  };

  // lowest bit of each field inside its register
  localparam [4*NF-1:0] FLD_POS = {
    `IPRM_POS_PARP,    // [R12]
    `IPRM_POS_CMP5,    // [R11]
    `IPRM_POS_CAP3,    // [R10]
    `IPRM_POS_CAP4,
    `IPRM_POS_CAP5,
    `IPRM_POS_SPIFLT,  // [R9]
    `IPRM_POS_SPIEVT,
    `IPRM_POS_TMR5,    // [R8]
    `IPRM_POS_EXT2,
    `IPRM_POS_SER2RX,
    `IPRM_POS_SER2TX,
    `IPRM_POS_CMP3,    // [R7]
    `IPRM_POS_CMP4,
    `IPRM_POS_TMR4,
    `IPRM_POS_EXT1     // [R6]
  };

  wire                    setup_rd;   // read in its setup cycle
  wire                    access_wr;  // mapped write completing
  wire [2:0]              reg_sel;    // addressed register index
  wire                    sel_valid;  // address hits the bank
  wire [3*NF-1:0]         field_q;    // all stored codes, flat
  wire [NF-1:0]           field_en;   // per field nonzero flag
  reg  [`IPRM_DATA_W-1:0] rd_word;    // assembled read value
  reg  [`IPRM_DATA_W-1:0] prdata_reg; // registered read data
  reg  [`IPRM_DATA_W-1:0] prdata_next;
  integer                 k;          // field loop index

  // bus phase decode and error answer
  iprm_apb_if #(
    .ADDR_W    (ADDR_W)
  ) u_apb (
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pready    (pready),
    .pslverr   (pslverr),
    .setup_rd  (setup_rd),
    .access_wr (access_wr),
    .reg_sel   (reg_sel),
    .sel_valid (sel_valid)
  );

  // one storage cell per priority field
  genvar gi;
  generate
    for (gi = 0; gi < NF; gi = gi + 1) begin : g_fld
      // placement of this field, fixed per instance
      localparam [2:0] RIDX = FLD_REG[3*gi+2:3*gi];
      localparam [3:0] BPOS = FLD_POS[4*gi+3:4*gi];
      wire             hit;  // write addressed to this field

      // only the owning register and byte lane can write it
      assign hit = access_wr & (reg_sel == RIDX) &
                   pstrb[BPOS[3]];  // [R14]

      iprm_field #(
        .RST_VAL (`IPRM_RST_LEVEL)
      ) u_fld (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (hit),
        .wr_data (pwdata[BPOS+2:BPOS]),  // [R1]
        .level   (field_q[3*gi+2:3*gi]),
        .enabled (field_en[gi])
      );
    end
  endgenerate

  // place every field of the addressed register, rest stay zero
  always @* begin
    rd_word = {`IPRM_DATA_W{1'b0}};  // [R4]
    for (k = 0; k < NF; k = k + 1) begin
      if (FLD_REG[3*k +: 3] == reg_sel) begin
        rd_word[FLD_POS[4*k +: 4] +: 3] = field_q[3*k +: 3];
      end
    end
  end

  // read data settles in the setup cycle so prdata is a flop
  always @* begin
    prdata_next = prdata_reg;
    if (setup_rd) begin
      if (sel_valid) begin
        prdata_next = rd_word;  // [R4]
      end else begin
        // unmapped reads return zero alongside the error
        prdata_next = {`IPRM_DATA_W{1'b0}};
      end
    end
  end

  // read data register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= {`IPRM_DATA_W{1'b0}};
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  // per source levels toward the arbiter; the arbiter must treat
  // a zero level as no request, equal levels are legal
  assign ext_irq1_level        = field_q[2:0];    // [R6]
  assign timer4_level          = field_q[5:3];    // [R7]
  assign compare4_level        = field_q[8:6];
  assign compare3_level        = field_q[11:9];
  assign serial2_tx_level      = field_q[14:12];  // [R8]
  assign serial2_rx_level      = field_q[17:15];
  assign ext_irq2_level        = field_q[20:18];
  assign timer5_level          = field_q[23:21];
  assign spi_unit2_event_level = field_q[26:24];  // [R9]
  assign spi_unit2_fault_level = field_q[29:27];
  assign capture5_level        = field_q[32:30];  // [R10]
  assign capture4_level        = field_q[35:33];
  assign capture3_level        = field_q[38:36];
  assign compare5_level        = field_q[41:39];  // [R11]
  assign parallel_port_level   = field_q[44:42];  // [R12]

  // zero code drops the source out of arbitration
  assign src_enabled = field_en;  // [R3]

endmodule

/* iprm_defs.vh */
// constants shared by the mid interrupt priority register bank
`ifndef IPRM_DEFS_VH
`define IPRM_DEFS_VH

// bus geometry
`define IPRM_ADDR_W      12
`define IPRM_DATA_W      32
`define IPRM_NUM_REGS    7
`define IPRM_LAST_IDX    3'h6
`define IPRM_IDX_W       3

// register indexes, byte address is index times four
`define IPRM_IDX_EXT1    3'h0
`define IPRM_IDX_TMR4    3'h1
`define IPRM_IDX_SER2    3'h2
`define IPRM_IDX_SPI2    3'h3
`define IPRM_IDX_CAP     3'h4
`define IPRM_IDX_CMP5    3'h5
`define IPRM_IDX_PARP    3'h6

// priority field geometry and codes
`define IPRM_FLD_W       3
`define IPRM_NUM_FLDS    15
`define IPRM_RST_LEVEL   3'h4
`define IPRM_LVL_OFF     3'h0
`define IPRM_LVL_MIN     3'h1
`define IPRM_LVL_MAX     3'h7

// lowest bit of each priority field within its register
`define IPRM_POS_EXT1    4'h0
`define IPRM_POS_TMR4    4'hc
`define IPRM_POS_CMP4    4'h8
`define IPRM_POS_CMP3    4'h4
`define IPRM_POS_SER2TX  4'hc
`define IPRM_POS_SER2RX  4'h8
`define IPRM_POS_EXT2    4'h4
`define IPRM_POS_TMR5    4'h0
`define IPRM_POS_SPIEVT  4'h4
`define IPRM_POS_SPIFLT  4'h0
`define IPRM_POS_CAP5    4'hc
`define IPRM_POS_CAP4    4'h8
`define IPRM_POS_CAP3    4'h4
`define IPRM_POS_CMP5    4'h4
`define IPRM_POS_PARP    4'h4

`endif

/* iprm_field.v */
// one three-bit priority field with its enable decode
`timescale 1ns/1ps
`include "iprm_defs.vh"

module iprm_field #(
  parameter [2:0] RST_VAL = `IPRM_RST_LEVEL
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       wr_en,
  input  wire [2:0] wr_data,
  output wire [2:0] level,
  output wire       enabled
);

  reg [2:0] level_reg;   // stored priority code
  reg [2:0] level_next;  // value for the next edge

  // hold unless the bus writes this field
  always @* begin
    level_next = level_reg;
    if (wr_en) begin
      level_next = wr_data;  // [R1]
    end
  end

  // power-on value is level four
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= RST_VAL;  // [R5]
    end else begin
      level_reg <= level_next;  // [R14]
    end
  end

  // code is the level itself, one lowest, seven highest
  assign level   = level_reg;  // [R2]
  // zero code takes the source out of arbitration
  assign enabled = (level_reg != `IPRM_LVL_OFF);  // [R3]

endmodule

/* iprm_apb_if.v */
// apb slave front end: phase strobes and address decode
`timescale 1ns/1ps
`include "iprm_defs.vh"

module iprm_apb_if #(
  parameter ADDR_W = `IPRM_ADDR_W
) (
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  output wire              pready,
  output wire              pslverr,
  output wire              setup_rd,
  output wire              access_wr,
  output wire [2:0]        reg_sel,
  output wire              sel_valid
);

  wire hi_zero;  // address bits above the bank are clear
  wire aligned;  // word aligned access

  assign hi_zero   = (paddr[ADDR_W-1:5] == {(ADDR_W-5){1'b0}});
  assign aligned   = (paddr[1:0] == 2'h0);
  assign reg_sel   = paddr[4:2];
  // index seven and anything outside the bank is unmapped
  assign sel_valid = hi_zero & aligned & (reg_sel <= `IPRM_LAST_IDX);

  // zero wait state: the access phase always completes at once
  assign pready    = 1'b1;
  // unmapped access answers with an error, nothing is stored
  assign pslverr   = psel & penable & ~sel_valid;
  // read data is captured at the setup edge so it is a flop
  assign setup_rd  = psel & ~penable & ~pwrite;
  // writes take effect only at the completing access edge
  assign access_wr = psel & penable & pwrite & sel_valid;

endmodule

/* iprm_monitor.sv */
// assertion checker for the mid interrupt priority register bank
`timescale 1ns/1ps
`include "iprm_defs.vh"
module iprm_monitor #(
  parameter ADDR_W = 12
) (
  input wire              pclk,
  input wire              presetn,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       pwdata,
  input wire [3:0]        pstrb,
  input wire [31:0]       prdata,
  input wire              pslverr,
  input wire [2:0]        ext_irq1_level,
  input wire [2:0]        timer4_level,
  input wire [2:0]        parallel_port_level,
  input wire [14:0]       src_enabled
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc_wr = psel && penable && pwrite;  // write access phase
  wire acc_rd = psel && penable && !pwrite; // read access phase
  // write into the first register with its low lane enabled
  sequence s_wr_ext1;
    acc_wr && paddr == 0 && pstrb[0];
  endsequence
  // read setup of the first register
  sequence s_rd_setup_ext1;
    psel && !penable && !pwrite && paddr == 0;
  endsequence
  property p_reset_level;
    $rose(presetn) |-> ext_irq1_level == 3'h4 && parallel_port_level == 3'h4;
  endproperty
  property p_ext1_wr;
    s_wr_ext1 |=> ext_irq1_level == $past(pwdata[2:0]);
  endproperty
  property p_tmr4_wr;
    acc_wr && paddr == 12'h004 && pstrb[1] |=>
      timer4_level == $past(pwdata[14:12]);
  endproperty
  property p_parp_wr;
    acc_wr && paddr == 12'h018 && pstrb[0] |=>
      parallel_port_level == $past(pwdata[6:4]);
  endproperty
  property p_hold;
    !(acc_wr && paddr == 0) |=> $stable(ext_irq1_level);
  endproperty
  property p_unused;
    acc_rd && !pslverr |-> prdata[31:15] == 0 && prdata[11] == 0 &&
      prdata[7] == 0 && prdata[3] == 0;
  endproperty
  property p_enable;
    src_enabled[0] == (ext_irq1_level != 0) &&
      src_enabled[1] == (timer4_level != 0) &&
      src_enabled[14] == (parallel_port_level != 0);
  endproperty
  property p_unmapped;
    acc_rd && paddr == 12'h01c |-> pslverr && prdata == 0;
  endproperty
  // write, one idle cycle, then read back the ext1 field bits 2-0 just written
  property p_rdback;
    s_wr_ext1 ##2 s_rd_setup_ext1 |=> prdata[2:0] == $past(pwdata[2:0], 3);
  endproperty
  a_reset_level: assert property (p_reset_level)
    else $error("field not at level four after reset");
  a_ext1_wr: assert property (p_ext1_wr)
    else $error("ext irq1 level did not take write");
  a_tmr4_wr: assert property (p_tmr4_wr)
    else $error("timer4 level did not take write");
  a_parp_wr: assert property (p_parp_wr)
    else $error("parallel port level did not take write");
  a_hold: assert property (p_hold)
    else $error("ext irq1 level changed without write");
  a_unused: assert property (p_unused)
    else $error("unused bit read as one");
  a_enable: assert property (p_enable)
    else $error("enable does not match nonzero code");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  a_rdback: assert property (p_rdback)
    else $error("readback differs from written field");
endmodule
bind iprm_regs iprm_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pslverr(pslverr), .ext_irq1_level(ext_irq1_level),
  .timer4_level(timer4_level), .parallel_port_level(parallel_port_level),
  .src_enabled(src_enabled)
);

/* interrupt_priority_regs_mid_tb.sv */
// self-checking bench for the mid interrupt priority register bank
`timescale 1ns/1ps
module interrupt_priority_regs_mid_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = '0;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  wire  [2:0]  lv [0:14];
  wire  [14:0] src_enabled;
  int          errors = 0, comparisons = 0;
  // read values after reset, and masks of implemented bits
  logic [15:0] rst_v [0:6] = '{16'h0004, 16'h4440, 16'h4444, 16'h0044,
                               16'h4440, 16'h0040, 16'h0040};
  logic [15:0] msk [0:6] = '{16'h0007, 16'h7770, 16'h7777, 16'h0077,
                             16'h7770, 16'h0070, 16'h0070};
  // levels expected after writing 16'h7531 to every register
  logic [2:0]  pat [0:14] = '{1, 7, 5, 3, 7, 5, 3, 1, 3, 1, 7, 5, 3, 3, 3};
  iprm_regs dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq1_level(lv[0]), .timer4_level(lv[1]), .compare4_level(lv[2]),
    .compare3_level(lv[3]), .serial2_tx_level(lv[4]),
    .serial2_rx_level(lv[5]), .ext_irq2_level(lv[6]), .timer5_level(lv[7]),
    .spi_unit2_event_level(lv[8]), .spi_unit2_fault_level(lv[9]),
    .capture5_level(lv[10]), .capture4_level(lv[11]),
    .capture3_level(lv[12]), .compare5_level(lv[13]),
    .parallel_port_level(lv[14]), .src_enabled(src_enabled)
  );
  // 25 ns clock
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_lvl(int i, logic [2:0] e);
    comparisons++;
    if (lv[i] !== e) begin
      errors++;
      $display("ERROR level %0d expected %h seen %h", i, e, lv[i]);
    end
  endtask
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     logic [3:0] s, logic ee, logic [31:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    chk_word("pslverr", {31'h0, ee}, {31'h0, pslverr});
    if (!w) chk_word("prdata", e, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s, logic ee);
    apb(1'b1, a, d, s, ee, 32'h0);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e, logic ee);
    apb(1'b0, a, 32'h0, 4'h0, ee, e);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(4 * i, rst_v[i], 0);
    for (int i = 0; i < 15; i++) chk_lvl(i, 3'h4);
    chk_word("src_enabled", 32'h7fff, src_enabled);
    $display("test reset done");
    // every code in every field, unused bits written as ones
    for (int c = 0; c < 8; c++) begin
      for (int i = 0; i < 7; i++) wr(4 * i, {16'hffff, {4{1'b1, c[2:0]}}},
                                     4'hf, 0);
      @(negedge pclk);
      for (int i = 0; i < 15; i++) chk_lvl(i, c[2:0]);
      chk_word("src_enabled", c ? 32'h7fff : 32'h0, src_enabled);
      for (int i = 0; i < 7; i++) rd(4 * i, {4{1'b0, c[2:0]}} & msk[i],
                                     0);
    end
    $display("test codes done");
    // distinct codes show where each field sits
    for (int i = 0; i < 7; i++) wr(4 * i, 32'h7531, 4'hf, 0);
    @(negedge pclk);
    for (int i = 0; i < 15; i++) chk_lvl(i, pat[i]);
    for (int i = 0; i < 7; i++) rd(4 * i, 32'h7531 & msk[i], 0);
    $display("test placement done");
    // byte lanes: upper lane clears timer4 and compare4 only
    wr(12'h004, 32'h0, 4'b0010, 0);
    @(negedge pclk);
    chk_lvl(1, 3'h0);
    chk_lvl(3, 3'h3);
    chk_word("src_enabled", 32'h7ff9, src_enabled);
    rd(12'h004, 32'h0030, 0);
    $display("test strobes done");
    // unmapped and misaligned addresses are refused
    rd(12'h01c, 32'h0, 1);
    wr(12'h01c, 32'h0, 4'hf, 1);
    wr(12'h002, 32'h0, 4'hf, 1);
    rd(12'h020, 32'h0, 1);
    wr(12'h020, 32'h0, 4'hf, 1);
    rd(12'h000, 32'h0001, 0);
    wr(12'h000, 32'h0006, 4'h1, 0);
    rd(12'h000, 32'h0006, 0);
    $display("test refusals done");
    // second reset in mid-run
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h008, 32'h4444, 0);
    $display("test second reset done");
    wrap_up;
  end
endmodule
